/* File: hw/bmds_pkg.sv */
// Package: register map, field layout and reset values of the drop statistics block
package bmds_pkg;
	localparam logic [15:0] REG_CONFIG       = 16'h1c00;
	localparam logic [15:0] REG_BCAST_LIMIT  = 16'h1c04;
	localparam logic [15:0] REG_DROP_PORT0   = 16'h1c05;
	localparam logic [15:0] REG_DROP_PORT1   = 16'h1c06;
	localparam logic [15:0] REG_DROP_PORT2   = 16'h1c07;
	localparam logic [15:0] REG_INIT_STATUS  = 16'h1c08;
	localparam int          NUM_PORTS        = 3;
	localparam int          CFG_TEST_BIT     = 6;
	localparam int          READY_BIT        = 0;
	localparam logic [7:0]  BCAST_LIMIT_RST  = 8'h31;
	localparam logic [31:0] DROP_CNT_RST     = 32'h0000_0000;
	localparam logic [31:0] DROP_CNT_MAX     = 32'hffff_ffff;
	localparam logic [31:0] DROP_CNT_TEST    = 32'h07ff_fffc;
	localparam int          BUFFER_BYTES     = 128;
	localparam logic [31:0] CONFIG_RST       = 32'h0000_0000;
endpackage

/* File: hw/bmds_top.sv */
// Module: broadcast limit, per-port drop counters and table-ready status
`timescale 1ns/1ns

// Functional notes
// RL1 - An 8-bit limit, reset 31h, caps buffers held by broadcast, multicast and unknown unicast.
// RL2 - Limits and usage are counted in buffers of 128 bytes each.
// RL3 - Each ingress port 0..2 has its own 32-bit drop counter for space and rate discards.
// RL4 - Reading a drop counter returns its value and clears it; reset value is zero.
// RL5 - Drop counters stop at all ones instead of wrapping.
// RL6 - A read-only ready flag at bit 0 shows table initialization done after fabric reset.
// RL7 - The ready flag reads zero after reset and sets itself when table init completes.
// RL8 - With counter test mode set, a read loads the counter with the test value 07fffffch.
// RL9 - A drop that coincides with a clearing read is kept, leaving the counter at one.
module bmds_top (
	input  wire logic                            REF_CLK,
	input  wire logic                            RST_N,
	input  wire logic [15:0]                     REG_ADDR,
	input  wire logic                            REG_WR,
	input  wire logic                            REG_RD,
	input  wire logic [31:0]                     REG_WDATA,
	output logic      [31:0]                     REG_RDATA,
	input  wire logic                            TABLE_INIT_DONE,
	input  wire logic [bmds_pkg::NUM_PORTS-1:0]  DROP_EVENT,
	input  wire logic [7:0]                      BCAST_BUFFERS_USED,
	input  wire logic                            BCAST_REQUEST,
	output logic                                 BCAST_ADMIT,
	output logic      [7:0]                      BCAST_LIMIT,
	output logic                                 COUNTER_TEST_MODE
);
	import bmds_pkg::*;

	// ======================================================
	// Configuration registers
	logic [31:0] config_q;
	logic [7:0]  bcast_limit_q;
	logic        tables_initialized_flag_q;
	logic [31:0] drop_cnt_q [NUM_PORTS];

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			config_q      <= CONFIG_RST;
			bcast_limit_q <= BCAST_LIMIT_RST; // [RL1]
		end else if (REG_WR) begin
			if (REG_ADDR == REG_CONFIG)
				config_q <= {25'h0, REG_WDATA[6:0]};
			if (REG_ADDR == REG_BCAST_LIMIT)
				bcast_limit_q <= REG_WDATA[7:0];
		end
	end

	assign COUNTER_TEST_MODE = config_q[CFG_TEST_BIT];
	assign BCAST_LIMIT       = bcast_limit_q;

	limit_write_a: assert property ( // [RL1]
		@(posedge REF_CLK) disable iff (!RST_N)
		REG_WR && REG_ADDR == REG_BCAST_LIMIT |=>
		bcast_limit_q == $past(REG_WDATA[7:0]))
		else $error("limit write not taken");
	limit_holds_a: assert property ( // [RL1]
		@(posedge REF_CLK) disable iff (!RST_N)
		!(REG_WR && REG_ADDR == REG_BCAST_LIMIT) |=>
		bcast_limit_q == $past(bcast_limit_q))
		else $error("limit changed without write");
	cfg_reserved_zero_a: assert property ( // [RL8]
		@(posedge REF_CLK) disable iff (!RST_N)
		config_q[31:7] == 25'h0)
		else $error("reserved config bits set");
	test_mode_write_a: assert property ( // [RL8]
		@(posedge REF_CLK) disable iff (!RST_N)
		REG_WR && REG_ADDR == REG_CONFIG |=>
		COUNTER_TEST_MODE == $past(REG_WDATA[CFG_TEST_BIT]))
		else $error("test mode write not taken");
	config_reset_a: assert property ( // [RL8]
		@(posedge REF_CLK)
		!RST_N |=> config_q == CONFIG_RST)
		else $error("config reset value wrong");

	// ======================================================
	// Broadcast admission
	// Usage is in 128-byte buffers, so one more buffer must still fit
	always_comb begin
		BCAST_ADMIT = BCAST_REQUEST && (BCAST_BUFFERS_USED < bcast_limit_q); // [RL1] [RL2]
	end

	bcast_idle_a: assert property ( // [RL1]
		@(posedge REF_CLK) disable iff (!RST_N)
		!BCAST_REQUEST |-> !BCAST_ADMIT)
		else $error("broadcast admitted without request");

	// ======================================================
	// Table ready flag
	// Self-sets only; cleared by the same reset that clears the fabric
	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			tables_initialized_flag_q <= 1'b0; // [RL7]
		else if (TABLE_INIT_DONE)
			tables_initialized_flag_q <= 1'b1; // [RL6] [RL7]
	end

	ready_holds_a: assert property ( // [RL6]
		@(posedge REF_CLK) disable iff (!RST_N)
		tables_initialized_flag_q |=> tables_initialized_flag_q)
		else $error("ready flag dropped without reset");
	ready_needs_init_a: assert property ( // [RL7]
		@(posedge REF_CLK) disable iff (!RST_N)
		!tables_initialized_flag_q && !TABLE_INIT_DONE |=>
		!tables_initialized_flag_q)
		else $error("ready flag set before table init");

	// ======================================================
	// Drop counters
	function automatic logic [15:0] port_addr(input int p);
		case (p)
			0:       port_addr = REG_DROP_PORT0;
			1:       port_addr = REG_DROP_PORT1;
			default: port_addr = REG_DROP_PORT2;
		endcase
	endfunction

	logic [NUM_PORTS-1:0] cnt_read;

	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_cnt
			assign cnt_read[g] = REG_RD && (REG_ADDR == port_addr(g));
			always_ff @(posedge REF_CLK) begin
				if (!RST_N)
					drop_cnt_q[g] <= DROP_CNT_RST; // [RL4]
				else if (cnt_read[g]) begin
					if (config_q[CFG_TEST_BIT])
						drop_cnt_q[g] <= DROP_CNT_TEST; // [RL8]
					else
						drop_cnt_q[g] <= {31'h0, DROP_EVENT[g]}; // [RL4] [RL9]
				end else if (DROP_EVENT[g] && drop_cnt_q[g] != DROP_CNT_MAX)
					drop_cnt_q[g] <= drop_cnt_q[g] + 32'h1; // [RL3] [RL5]
			end

			clear_keeps_drop_a: assert property ( // [RL9]
				@(posedge REF_CLK) disable iff (!RST_N)
				cnt_read[g] && !config_q[CFG_TEST_BIT] |=>
				drop_cnt_q[g] == {31'h0, $past(DROP_EVENT[g])})
				else $error("counter wrong after clearing read");
			count_saturates_a: assert property ( // [RL5]
				@(posedge REF_CLK) disable iff (!RST_N)
				drop_cnt_q[g] == DROP_CNT_MAX && !cnt_read[g] |=>
				drop_cnt_q[g] == DROP_CNT_MAX)
				else $error("counter left its maximum");
			count_increments_a: assert property ( // [RL3]
				@(posedge REF_CLK) disable iff (!RST_N)
				DROP_EVENT[g] && !cnt_read[g] && drop_cnt_q[g] != DROP_CNT_MAX |=>
				drop_cnt_q[g] == $past(drop_cnt_q[g]) + 32'h1)
				else $error("drop not counted");
			test_load_a: assert property ( // [RL8]
				@(posedge REF_CLK) disable iff (!RST_N)
				cnt_read[g] && config_q[CFG_TEST_BIT] |=>
				drop_cnt_q[g] == DROP_CNT_TEST)
				else $error("test value not loaded");
			count_holds_idle_a: assert property ( // [RL3]
				@(posedge REF_CLK) disable iff (!RST_N)
				!cnt_read[g] && !DROP_EVENT[g] |=>
				drop_cnt_q[g] == $past(drop_cnt_q[g]))
				else $error("counter moved without drop or read");
			port_read_value_a: assert property ( // [RL4]
				@(posedge REF_CLK) disable iff (!RST_N)
				cnt_read[g] |=> REG_RDATA == $past(drop_cnt_q[g]))
				else $error("counter read returned wrong value");
			drop_reset_a: assert property ( // [RL4]
				@(posedge REF_CLK)
				!RST_N |=> drop_cnt_q[g] == DROP_CNT_RST)
				else $error("counter reset value wrong");
		end
	endgenerate

	// ======================================================
	// Status word; only the ready bit is defined
	logic [31:0] status_word;

	always_comb begin
		status_word            = 32'h0;
		status_word[READY_BIT] = tables_initialized_flag_q; // [RL6]
	end

	// ======================================================
	// Read data, registered; unmapped and reserved bits read zero
	// Counter value is captured at the same edge that clears it
	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			REG_RDATA <= 32'h0;
		else if (REG_RD) begin
			case (REG_ADDR)
				REG_CONFIG:      REG_RDATA <= config_q;
				REG_BCAST_LIMIT: REG_RDATA <= {24'h0, bcast_limit_q};
				REG_DROP_PORT0:  REG_RDATA <= drop_cnt_q[0]; // [RL4]
				REG_DROP_PORT1:  REG_RDATA <= drop_cnt_q[1];
				REG_DROP_PORT2:  REG_RDATA <= drop_cnt_q[2];
				REG_INIT_STATUS: REG_RDATA <= status_word; // [RL6]
				default:         REG_RDATA <= 32'h0;
			endcase
		end
	end

	read_returns_count_a: assert property ( // [RL4]
		@(posedge REF_CLK) disable iff (!RST_N)
		REG_RD && REG_ADDR == REG_DROP_PORT1 |=>
		REG_RDATA == $past(drop_cnt_q[1]))
		else $error("counter read returned wrong value");
	ready_sticks_a: assert property ( // [RL7]
		@(posedge REF_CLK) disable iff (!RST_N)
		TABLE_INIT_DONE |=> tables_initialized_flag_q ##1 tables_initialized_flag_q)
		else $error("ready flag did not set");
	ready_after_reset_a: assert property ( // [RL7]
		@(posedge REF_CLK)
		!RST_N |=> !tables_initialized_flag_q)
		else $error("ready flag set after reset");
	bcast_cap_a: assert property ( // [RL1]
		@(posedge REF_CLK) disable iff (!RST_N)
		BCAST_ADMIT |-> BCAST_BUFFERS_USED < BCAST_LIMIT)
		else $error("broadcast admitted over limit");
	limit_reset_a: assert property ( // [RL1]
		@(posedge REF_CLK)
		!RST_N |=> bcast_limit_q == BCAST_LIMIT_RST)
		else $error("limit reset value wrong");
	status_read_a: assert property ( // [RL6]
		@(posedge REF_CLK) disable iff (!RST_N)
		REG_RD && REG_ADDR == REG_INIT_STATUS |=>
		REG_RDATA == {31'h0, $past(tables_initialized_flag_q)})
		else $error("status read returned wrong value");
	rdata_holds_a: assert property ( // [RL4]
		@(posedge REF_CLK) disable iff (!RST_N)
		!REG_RD |=> REG_RDATA == $past(REG_RDATA))
		else $error("read data changed without read");

endmodule

/* File: bench/bmds_init_model.sv */
// Model of the table init logic that feeds the ready flag
`timescale 1ns/1ns
module bmds_init_model #(
	parameter int INIT_CYCLES = 6
) (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      done
);
	logic [3:0] count_q;
	// ====================
	// Init: restarts on every fabric reset, so ready must fall with it
	always_ff @(posedge clk) begin
		if (!rst_n)
			count_q <= 4'h0;
		else if (!done)
			count_q <= count_q + 4'h1;
	end
	assign done = (count_q == 4'(INIT_CYCLES));
endmodule

/* File: bench/bmds_top_tb.sv */
// Testbench: registers, drops and admission of the drop statistics block
`timescale 1ns/1ns
module bmds_top_tb;
	import bmds_pkg::*;
	logic        clk, rst_n, wr, rd, init_done, req, admit, tmode;
	logic [15:0] addr;
	logic [31:0] wdata, rdata;
	logic [2:0]  drop;
	logic [7:0]  used, limit;
	int          n_mismatch, comparisons;
	bmds_init_model i_init (.clk(clk), .rst_n(rst_n), .done(init_done));
	bmds_top i_dut (.REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .TABLE_INIT_DONE(init_done), .DROP_EVENT(drop),
		.BCAST_BUFFERS_USED(used), .BCAST_REQUEST(req), .BCAST_ADMIT(admit),
		.BCAST_LIMIT(limit), .COUNTER_TEST_MODE(tmode));
	// ====================
	// Tasks
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task chk(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task step;
		@(posedge clk);
		#1;
	endtask
	task wr_reg(logic [15:0] a, logic [31:0] d);
		step;
		{addr, wdata, wr} = {a, d, 1'b1};
		step;
		wr = 0;
	endtask
	// Drop mask rides with the read to hit the coincidence case
	task rd_reg(logic [15:0] a, logic [31:0] exp, logic [2:0] m = 3'h0);
		step;
		{addr, rd, drop} = {a, 1'b1, m};
		step;
		{rd, drop} = 4'h0;
		chk("rdata", rdata, exp);
	endtask
	task pulse(logic [2:0] m);
		step;
		drop = m;
		step;
		drop = 0;
	endtask
	task give_verdict;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ====================
	// Sequence
	initial begin
		#20000;
		n_mismatch++;
		give_verdict;
	end
	initial begin
		{rst_n, wr, rd, req, drop, used, addr, wdata} = 0;
		repeat (4) step;
		rst_n = 1;
		rd_reg(REG_INIT_STATUS, 0);
		repeat (8) step;
		rd_reg(REG_INIT_STATUS, 1);
		rd_reg(REG_BCAST_LIMIT, 32'h31);
		wr_reg(REG_DROP_PORT0, 32'h5);
		wr_reg(REG_BCAST_LIMIT, 32'h10);
		chk("limit", limit, 32'h10);
		{req, used} = {1'b1, 8'h0f};
		step;
		chk("admit", admit, 1);
		used = 8'h10;
		step;
		chk("admit", admit, 0);
		{req, used} = {1'b0, 8'h0f};
		step;
		chk("admit", admit, 0);
		for (int i = 0; i < 4; i++) pulse(3'b111 << (i > 1 ? i - 1 : 0));
		for (int p = 0; p < 3; p++) rd_reg(16'(REG_DROP_PORT0 + p), p + 2);
		for (int p = 0; p < 3; p++) rd_reg(16'(REG_DROP_PORT0 + p), 0);
		pulse(3'h1);
		rd_reg(REG_DROP_PORT0, 1, 3'h1);
		rd_reg(REG_DROP_PORT0, 1);
		wr_reg(REG_CONFIG, 32'hffff_ff40);
		chk("test mode", tmode, 1);
		rd_reg(REG_CONFIG, 32'h40);
		rd_reg(REG_DROP_PORT2, 0);
		pulse(3'h4);
		rd_reg(REG_DROP_PORT2, DROP_CNT_TEST + 1);
		rd_reg(16'h1c09, 0);
		rst_n = 0;
		repeat (2) step;
		rst_n = 1;
		rd_reg(REG_INIT_STATUS, 0);
		rd_reg(REG_CONFIG, 0);
		chk("limit", limit, 32'h31);
		rd_reg(REG_DROP_PORT2, 0);
		repeat (8) step;
		rd_reg(REG_INIT_STATUS, 1);
		give_verdict;
	end
endmodule
